// ===== hdl/eeprom_front.sv
/*
  Two-wire slave front end of a small serial EEPROM: Start/Stop
  detection, address and word address decode, acknowledge, read byte
  shifting, programming launch and Standby/reset handling.
  Assumes the array logic answers rd_req with rd_byte before the next
  SCL fall and ends a programming cycle with prog_done.
*/
// Summary of operation
// - SDA fall with SCL high is Start
// - ignore bus activity until a Start
// - SDA rise with SCL high is Stop
// - Stop ending a write launches programming
// - other Stops return to Standby
// - acknowledge holds SDA low whole ninth clock
// - Standby at power-up, read Stop, operation end
// - power-on reset silences, release enters Standby
// - brown-out resets at once, aborts, stays silent
// - write-protect pin or protect bit blocks writes except to the protect bit
// - address byte: type, chip select, direction
// - type 1010 selects main array
// - type 1011 selects auxiliary space
// - chip-select bits must match strap inputs
// - address bit zero gives read or write
// - ack matching address, else nack and Standby
// - lock reached only with write direction
// - unique identifier reached only by reads
// - acknowledge the single word address byte
// - aux word bits 7:6 pick function
// - sample on SCL rise, change on fall
// - write-protect still acks address, nacks data except to the protect bit
`timescale 1ns/1ps
module eeprom_front (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl_link_clk,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       chip_select_bit_zero,
  input  wire logic       chip_select_bit_one,
  input  wire logic       chip_select_bit_two,
  input  wire logic       write_protect_pin,
  input  wire logic       below_power_on_threshold,
  input  wire logic       below_brownout_threshold,
  input  wire logic       software_protect_bit,
  input  wire logic       identification_page_locked,
  input  wire logic       prog_done,
  input  wire logic [7:0] rd_byte,
  output logic            rd_req,
  output logic            wr_strobe,
  output logic [7:0]      wr_byte,
  output logic            prog_start,
  output logic            space_aux,
  output logic            read_dir,
  output logic [7:0]      word_addr,
  output logic [1:0]      aux_function,
  output logic [3:0]      aux_index,
  output logic            standby,
  output logic            busy
);
  import eeprom_front_pkg::*;

  // ------------------------------------------------------------------
  // link clock domain
  // ------------------------------------------------------------------
  logic       rise_tgl_ff;
  logic       tgl_s1_ff;
  logic       tgl_s2_ff;
  logic       tgl_d_ff;
  logic       rise_ev;

  // one toggle per SCL rising edge; SDA is taken later, at the filtered SCL rise in the clk domain
  always_ff @(posedge scl_link_clk or posedge rst) begin
    if (rst) begin
      rise_tgl_ff <= 1'b0;
    end else begin
      rise_tgl_ff <= ~rise_tgl_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tgl_s1_ff <= 1'b0;
      tgl_s2_ff <= 1'b0;
      tgl_d_ff  <= 1'b0;
    end else begin
      tgl_s1_ff <= rise_tgl_ff;
      tgl_s2_ff <= tgl_s1_ff;
      tgl_d_ff  <= tgl_s2_ff;
    end
  end

  assign rise_ev = tgl_s2_ff ^ tgl_d_ff;

  // ------------------------------------------------------------------
  // pin synchronisers and line filter
  // ------------------------------------------------------------------
  logic [7:0] pins;
  logic [7:0] sync1_ff;
  logic [7:0] sync2_ff;
  logic [1:0] line_d_ff;
  logic [1:0] filt_ff;
  logic [1:0] filt_d_ff;
  logic [1:0] line_diff;
  logic       sda_f;
  logic       scl_f;
  logic       start_ev;
  logic       stop_ev;
  logic       scl_fall;
  logic       scl_rise;
  logic       rise_seen_ff;
  logic       bit_ev;
  logic       hold;
  logic [2:0] cs_pins;
  logic       protect;

  assign pins = {below_brownout_threshold, below_power_on_threshold, write_protect_pin,
                 chip_select_bit_two, chip_select_bit_one, chip_select_bit_zero,
                 scl_link_clk, sda_in};

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_ff <= RST_PINS;
      sync2_ff <= RST_PINS;
    end else begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
    end
  end

  // a line level is accepted only after two equal samples
  assign line_diff = sync2_ff[1:0] ^ line_d_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      line_d_ff <= RST_LINES;
      filt_ff   <= RST_LINES;
      filt_d_ff <= RST_LINES;
    end else begin
      line_d_ff <= sync2_ff[1:0];
      filt_ff   <= (~line_diff & sync2_ff[1:0]) | (line_diff & filt_ff);
      filt_d_ff <= filt_ff;
    end
  end

  assign sda_f    = filt_ff[PIN_SDA];
  assign scl_f    = filt_ff[PIN_SCL];
  assign start_ev = scl_f && filt_d_ff[PIN_SCL] && filt_d_ff[PIN_SDA] && !sda_f;
  assign stop_ev  = scl_f && filt_d_ff[PIN_SCL] && !filt_d_ff[PIN_SDA] && sda_f;
  assign scl_fall = filt_d_ff[PIN_SCL] && !scl_f;
  assign scl_rise = !filt_d_ff[PIN_SCL] && scl_f;
  assign bit_ev   = scl_rise && (rise_seen_ff || rise_ev);
  assign hold     = rst || sync2_ff[PIN_POR] || sync2_ff[PIN_BOR];
  assign cs_pins  = {sync2_ff[PIN_CS2], sync2_ff[PIN_CS1], sync2_ff[PIN_CS0]};
  assign protect  = sync2_ff[PIN_WP] || software_protect_bit;

  // a link rise waits for the filtered line, so an scl spike adds no bit
  always_ff @(posedge clk) begin
    if (rst) begin
      rise_seen_ff <= 1'b0;
    end else begin
      rise_seen_ff <= (rise_seen_ff || rise_ev) && !scl_rise;
    end
  end

  // ------------------------------------------------------------------
  // byte decisions
  // ------------------------------------------------------------------
  state_t     state_ff;
  phase_t     phase_ff;
  logic [3:0] cnt_ff;
  logic [7:0] shift_ff;
  logic [1:0] dcnt_ff;
  logic       ack_ff;
  logic       mack_ff;
  logic       aux_ff;
  logic       rd_ff;
  logic [7:0] word_ff;
  logic [1:0] fn;
  logic       byte_done;
  logic       addr_ok;
  logic       data_ok;
  logic       ack_now;
  logic       prog_ok;

  function automatic logic dev_match(input logic [7:0] b, input logic [2:0] cs);
    logic [3:0] kind;
    kind = b[7:TYPE_LSB];
    return (kind == TYPE_MAIN || kind == TYPE_AUX) && b[3:CS_LSB] == cs;
  endfunction

  assign fn        = word_ff[7:FN_LSB];
  assign byte_done = state_ff == RX_BYTE && scl_fall && cnt_ff == BYTE_BITS;
  assign addr_ok   = dev_match(shift_ff, cs_pins);

  always_comb begin
    data_ok = 1'b0;
    if (!aux_ff) begin
      data_ok = !protect;
    end else begin
      unique case (fn)
        FN_IDENTIFICATION_PAGE: data_ok = !protect && !identification_page_locked;
        FN_LOCK:    data_ok = !protect && !identification_page_locked && shift_ff[LOCK_DATA_BIT];
        FN_SWP:     data_ok = 1'b1;
        FN_UID:     data_ok = 1'b0;
      endcase
    end
  end

  always_comb begin
    ack_now = 1'b0;
    unique case (phase_ff)
      DEV_BYTE:  ack_now = addr_ok;
      WORD_BYTE: ack_now = 1'b1;
      DATA_BYTE: ack_now = data_ok;
    endcase
  end

  // single-byte functions program only when exactly one byte came in
  assign prog_ok = state_ff == RX_BYTE && phase_ff == DATA_BYTE && cnt_ff <= PROG_STOP_BITS
                   && dcnt_ff != 2'h0
                   && (!aux_ff || fn == FN_IDENTIFICATION_PAGE || dcnt_ff == 2'h1);

  // ------------------------------------------------------------------
  // transaction state machine
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (hold) begin
      state_ff <= IDLE;
      phase_ff <= DEV_BYTE;
      cnt_ff   <= 4'h0;
      shift_ff <= RST_BYTE;
      dcnt_ff  <= 2'h0;
      ack_ff   <= 1'b0;
      mack_ff  <= 1'b1;
      aux_ff   <= 1'b0;
      rd_ff    <= 1'b0;
      word_ff  <= RST_BYTE;
    end else if (state_ff == PROGRAM) begin
      if (prog_done) begin
        state_ff <= IDLE;
      end
    end else if (stop_ev) begin
      state_ff <= prog_ok ? PROGRAM : IDLE;
    end else if (start_ev) begin
      state_ff <= RX_BYTE;
      phase_ff <= DEV_BYTE;
      cnt_ff   <= 4'h0;
      dcnt_ff  <= 2'h0;
    end else begin
      unique case (state_ff)
        IDLE, IGNORE, PROGRAM: begin
          state_ff <= state_ff;
        end
        RX_BYTE: begin
          if (bit_ev && cnt_ff < BYTE_BITS) begin
            shift_ff <= {shift_ff[6:0], sda_f};
            cnt_ff   <= cnt_ff + 4'h1;
          end
          if (byte_done) begin
            state_ff <= ACK_SLOT;
            ack_ff   <= ack_now;
            unique case (phase_ff)
              DEV_BYTE: begin
                aux_ff <= shift_ff[7:TYPE_LSB] == TYPE_AUX;
                rd_ff  <= shift_ff[DIR_BIT];
              end
              WORD_BYTE: begin
                word_ff <= shift_ff;
              end
              DATA_BYTE: begin
                if (data_ok && dcnt_ff != DCNT_MAX) begin
                  dcnt_ff <= dcnt_ff + 2'h1;
                end
              end
            endcase
          end
        end
        ACK_SLOT: begin
          if (scl_fall) begin
            cnt_ff <= 4'h0;
            if (!ack_ff) begin
              state_ff <= phase_ff == DEV_BYTE ? IDLE : IGNORE;
            end else if (phase_ff == DEV_BYTE && rd_ff) begin
              state_ff <= TX_BYTE;
              shift_ff <= rd_byte;
            end else begin
              state_ff <= RX_BYTE;
              phase_ff <= phase_ff == DEV_BYTE ? WORD_BYTE : DATA_BYTE;
            end
          end
        end
        TX_BYTE: begin
          if (bit_ev && cnt_ff < BYTE_BITS) begin
            cnt_ff <= cnt_ff + 4'h1;
          end
          if (scl_fall && cnt_ff == BYTE_BITS) begin
            state_ff <= MASTER_ACK;
            mack_ff  <= 1'b1;
          end else if (scl_fall && cnt_ff != 4'h0) begin
            shift_ff <= {shift_ff[6:0], 1'b0};
          end
        end
        MASTER_ACK: begin
          if (bit_ev) begin
            mack_ff <= sda_f;
          end
          if (scl_fall) begin
            cnt_ff <= 4'h0;
            if (!mack_ff) begin
              state_ff <= TX_BYTE;
              shift_ff <= rd_byte;
            end else begin
              state_ff <= IGNORE;
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // data line drive and strobes
  // ------------------------------------------------------------------
  logic       oe_ff;
  logic       rd_req_ff;
  logic       wr_strobe_ff;
  logic [7:0] wr_byte_ff;
  logic       prog_start_ff;

  // drive is registered so the open-drain line never sees a glitch
  always_ff @(posedge clk) begin
    if (hold) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= (state_ff == ACK_SLOT && ack_ff)
               || (state_ff == TX_BYTE && !shift_ff[7]);
    end
  end

  always_ff @(posedge clk) begin
    if (hold) begin
      rd_req_ff     <= 1'b0;
      wr_strobe_ff  <= 1'b0;
      wr_byte_ff    <= RST_BYTE;
      prog_start_ff <= 1'b0;
    end else begin
      rd_req_ff     <= !stop_ev && !start_ev
                       && ((byte_done && phase_ff == DEV_BYTE && addr_ok && shift_ff[DIR_BIT])
                       || (state_ff == MASTER_ACK && bit_ev && !sda_f));
      wr_strobe_ff  <= !stop_ev && !start_ev && byte_done && phase_ff == DATA_BYTE && data_ok;
      prog_start_ff <= state_ff != PROGRAM && stop_ev && prog_ok;
      if (byte_done && phase_ff == DATA_BYTE) begin
        wr_byte_ff <= shift_ff;
      end
    end
  end

  assign sda_out      = 1'b0;
  assign sda_oe       = oe_ff;
  assign rd_req       = rd_req_ff;
  assign wr_strobe    = wr_strobe_ff;
  assign wr_byte      = wr_byte_ff;
  assign prog_start   = prog_start_ff;
  assign space_aux    = aux_ff;
  assign read_dir     = rd_ff;
  assign word_addr    = word_ff;
  assign aux_function = fn;
  assign aux_index    = word_ff[INDEX_WIDTH-1:0];
  assign standby      = state_ff == IDLE;
  assign busy         = state_ff == PROGRAM;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (hold);

  AST_START_RX: assert property (
    start_ev && !stop_ev && state_ff != PROGRAM |=> state_ff == RX_BYTE && cnt_ff == 4'h0
  ) else $error("start did not open an address byte");

  AST_IDLE_QUIET: assert property (
    state_ff == IDLE && !start_ev |=> state_ff == IDLE && !oe_ff
  ) else $error("standby reacted to bus activity without start");

  AST_STOP_ENDS: assert property (
    stop_ev && state_ff != PROGRAM |=> state_ff == IDLE || state_ff == PROGRAM
  ) else $error("stop did not end the transaction");

  AST_PROG_LAUNCH: assert property (
    stop_ev && prog_ok && state_ff != PROGRAM |=> prog_start_ff && state_ff == PROGRAM
  ) else $error("stop after write did not launch programming");

  AST_STOP_STANDBY: assert property (
    stop_ev && !prog_ok && state_ff != PROGRAM |=> standby && !prog_start_ff
  ) else $error("plain stop did not return to standby");

  AST_ACK_DRIVE: assert property (
    state_ff == ACK_SLOT && ack_ff ##1 state_ff == ACK_SLOT |-> sda_oe
  ) else $error("acknowledge not held low");

  AST_DONE_STANDBY: assert property (
    state_ff == PROGRAM && prog_done |=> standby
  ) else $error("end of programming did not enter standby");

  AST_HOLD_RESET: assert property (
    @(posedge clk) disable iff (1'b0) hold |=> standby && !sda_oe && !prog_start
  ) else $error("reset indication did not silence the device");

  AST_ADDR_NACK: assert property (
    byte_done && phase_ff == DEV_BYTE && !addr_ok && !stop_ev && !start_ev
    |=> state_ff == ACK_SLOT && !ack_ff ##1 !sda_oe
  ) else $error("mismatched address was acknowledged");

  AST_WORD_ACK: assert property (
    byte_done && phase_ff == WORD_BYTE && !stop_ev && !start_ev |=> ack_ff ##1 sda_oe
  ) else $error("word address byte not acknowledged");

  AST_WP_DATA: assert property (
    byte_done && phase_ff == DATA_BYTE && !aux_ff && protect |=> !ack_ff && !wr_strobe
  ) else $error("protected data byte was acknowledged");

  AST_UID_WRITE: assert property (
    byte_done && phase_ff == DATA_BYTE && aux_ff && fn == FN_UID |=> !ack_ff
  ) else $error("write to unique identifier acknowledged");

  COV_ADDR_ACK: cover property (byte_done && phase_ff == DEV_BYTE && addr_ok);
  COV_PROG:     cover property (prog_start);
  COV_READ:     cover property (state_ff == TX_BYTE ##1 state_ff == MASTER_ACK);
  COV_AUX_WR:   cover property (wr_strobe && aux_ff);

endmodule

// ===== hdl/eeprom_front_pkg.sv
/*
  Constants, field positions and state encodings for the serial EEPROM
  two-wire slave front end.
  Assumes it is compiled before any file that imports it.
*/
package eeprom_front_pkg;

  // ------------------------------------------------------------------
  // address byte and word address fields
  // ------------------------------------------------------------------
  localparam logic [3:0] TYPE_MAIN      = 4'ha;
  localparam logic [3:0] TYPE_AUX       = 4'hb;
  localparam int         TYPE_LSB       = 4;
  localparam int         CS_LSB         = 1;
  localparam int         DIR_BIT        = 0;
  localparam int         FN_LSB         = 6;
  localparam int         INDEX_WIDTH    = 4;
  localparam logic [1:0] FN_IDENTIFICATION_PAGE     = 2'h0;
  localparam logic [1:0] FN_LOCK        = 2'h1;
  localparam logic [1:0] FN_UID         = 2'h2;
  localparam logic [1:0] FN_SWP         = 2'h3;
  localparam int         LOCK_DATA_BIT  = 1;

  // ------------------------------------------------------------------
  // counts and reset values
  // ------------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam logic [3:0] PROG_STOP_BITS = 4'h1;
  localparam logic [1:0] DCNT_MAX       = 2'h3;
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [7:0] RST_PINS       = 8'h03;
  localparam logic [1:0] RST_LINES      = 2'h3;

  // ------------------------------------------------------------------
  // positions in the synchronised pin vector
  // ------------------------------------------------------------------
  localparam int PIN_SDA = 0;
  localparam int PIN_SCL = 1;
  localparam int PIN_CS0 = 2;
  localparam int PIN_CS1 = 3;
  localparam int PIN_CS2 = 4;
  localparam int PIN_WP  = 5;
  localparam int PIN_POR = 6;
  localparam int PIN_BOR = 7;

  // ------------------------------------------------------------------
  // state encodings
  // ------------------------------------------------------------------
  typedef enum logic [6:0] {
    IDLE       = 7'h01,
    RX_BYTE    = 7'h02,
    ACK_SLOT   = 7'h04,
    TX_BYTE    = 7'h08,
    MASTER_ACK = 7'h10,
    IGNORE     = 7'h20,
    PROGRAM    = 7'h40
  } state_t;

  typedef enum logic [2:0] {
    DEV_BYTE  = 3'h1,
    WORD_BYTE = 3'h2,
    DATA_BYTE = 3'h4
  } phase_t;

endpackage

// ===== testbench/tb_top.sv
/*
  Self-checking bench for the two-wire slave front end.
  Assumes twowire_master plays the bus master and the package is compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  import eeprom_front_pkg::*;

  logic       clk;
  logic       rst;
  logic [2:0] strap;
  logic       wp_pin;
  logic       por_act;
  logic       bor_act;
  logic       swp_bit;
  logic       id_locked;
  logic       prog_done;
  logic [7:0] rd_data;
  logic       m_scl;
  logic       m_sda_low;
  wire        sda_line;
  logic       sda_out;
  logic       sda_oe;
  logic       rd_req;
  logic       wr_strobe;
  logic [7:0] wr_byte;
  logic       prog_start;
  logic       space_aux;
  logic       read_dir;
  logic [7:0] word_addr;
  logic [1:0] aux_function;
  logic [3:0] aux_index;
  logic       standby;
  logic       busy;
  logic [7:0] prog_cnt = 8'h00;
  logic [7:0] wr_cnt = 8'h00;
  logic [7:0] rdq_cnt = 8'h00;
  logic [7:0] bad_addr [3] = '{8'ha8, 8'hae, 8'h9a};
  logic       ack;
  logic [7:0] got;
  logic [1:0] fn;
  int         err_count = 0;
  int         comparisons = 0;

  // open-drain wire with pull-up
  assign sda_line = (sda_oe ? sda_out : 1'b1) & ~m_sda_low;

  twowire_master i_twowire_master (.scl(m_scl), .sda_low(m_sda_low), .sda(sda_line));

  eeprom_front i_eeprom_front (
    .clk(clk), .rst(rst), .scl_link_clk(m_scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_bit_zero(strap[0]),
    .chip_select_bit_one(strap[1]), .chip_select_bit_two(strap[2]),
    .write_protect_pin(wp_pin), .below_power_on_threshold(por_act),
    .below_brownout_threshold(bor_act), .software_protect_bit(swp_bit),
    .identification_page_locked(id_locked), .prog_done(prog_done), .rd_byte(rd_data),
    .rd_req(rd_req), .wr_strobe(wr_strobe), .wr_byte(wr_byte),
    .prog_start(prog_start), .space_aux(space_aux), .read_dir(read_dir),
    .word_addr(word_addr), .aux_function(aux_function), .aux_index(aux_index),
    .standby(standby), .busy(busy)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // count the single-cycle strobes
  always @(negedge clk) begin
    if (prog_start === 1'b1) begin
      prog_cnt <= prog_cnt + 8'h01;
    end
    if (wr_strobe === 1'b1) begin
      wr_cnt <= wr_cnt + 8'h01;
    end
    if (rd_req === 1'b1) begin
      rdq_cnt <= rdq_cnt + 8'h01;
    end
  end

  task automatic conclude();
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic g, input logic e, input string what);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, g, e);
    end
  endtask

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string what);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
    end
  endtask

  task automatic settle();
    repeat (12) @(negedge clk);
  endtask

  task automatic head(input logic [7:0] a, input logic [7:0] w);
    i_twowire_master.start();
    i_twowire_master.write_byte(a, ack);
    chk_bit(ack, 1'b1, "address ack");
    i_twowire_master.write_byte(w, ack);
    chk_bit(ack, 1'b1, "word ack");
  endtask

  task automatic probe(input logic [7:0] a, input logic e);
    i_twowire_master.start();
    i_twowire_master.write_byte(a, ack);
    chk_bit(ack, e, "address answer");
    i_twowire_master.stop();
    settle();
  endtask

  task automatic data_stop(input logic [7:0] d, input logic e);
    i_twowire_master.write_byte(d, ack);
    chk_bit(ack, e, "data answer");
    i_twowire_master.stop();
    settle();
  endtask

  task automatic finish_prog();
    @(negedge clk);
    prog_done = 1'b1;
    @(negedge clk);
    prog_done = 1'b0;
    settle();
  endtask

  initial begin
    #300000;
    err_count++;
    conclude();
  end

  // ------------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    strap = 3'h5;
    {wp_pin, por_act, bor_act, swp_bit, id_locked, prog_done} = 6'h00;
    rd_data = 8'hc5;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    settle();
    chk_bit(standby, 1'b1, "standby after reset");
    i_twowire_master.write_byte(8'haa, ack);
    chk_bit(ack, 1'b0, "ack without start");
    i_twowire_master.stop();
    settle();
    head(8'haa, 8'h5c);
    chk_byte(word_addr, 8'h5c, "word address");
    chk_bit(space_aux, 1'b0, "main space");
    chk_bit(read_dir, 1'b0, "write direction");
    data_stop(8'h3a, 1'b1);
    chk_byte(wr_byte, 8'h3a, "written byte");
    chk_byte(wr_cnt, 8'h01, "write strobes");
    chk_byte(prog_cnt, 8'h01, "programming launched");
    chk_bit(busy, 1'b1, "busy");
    probe(8'haa, 1'b0);
    finish_prog();
    chk_bit(standby, 1'b1, "standby after programming");
    for (int k = 0; k < 2; k++) begin
      @(negedge clk);
      wp_pin = (k == 0);
      swp_bit = (k == 1);
      head(8'haa, 8'h10);
      data_stop(8'h55, 1'b0);
      chk_bit(standby, 1'b1, "standby after stop");
    end
    @(negedge clk);
    {wp_pin, swp_bit} = 2'h0;
    for (int k = 0; k < 4; k++) begin
      fn = k[1:0];
      head(8'hba, {fn, 6'h29});
      chk_bit(space_aux, 1'b1, "aux space");
      chk_byte({6'h00, aux_function}, {6'h00, fn}, "aux function");
      chk_byte({4'h0, aux_index}, 8'h09, "aux index");
      i_twowire_master.stop();
      settle();
      chk_bit(standby, 1'b1, "standby after stop");
    end
    chk_byte(prog_cnt, 8'h01, "no programming without data");
    head(8'hba, 8'h40);
    data_stop(8'h02, 1'b1);
    chk_byte(prog_cnt, 8'h02, "lock launched");
    finish_prog();
    head(8'hba, 8'h80);
    data_stop(8'h00, 1'b0);
    @(negedge clk);
    id_locked = 1'b1;
    head(8'hba, 8'h03);
    data_stop(8'h77, 1'b0);
    @(negedge clk);
    id_locked = 1'b0;
    chk_byte(prog_cnt, 8'h02, "refused writes not launched");
    wp_pin = 1'b1;
    head(8'hba, 8'hc0);
    i_twowire_master.write_byte(8'h01, ack);
    chk_bit(ack, 1'b1, "protect bit write answer");
    data_stop(8'h00, 1'b1);
    chk_byte(prog_cnt, 8'h02, "two-byte protect write discarded");
    head(8'hba, 8'hc0);
    data_stop(8'h01, 1'b1);
    chk_byte(prog_cnt, 8'h03, "protect bit write launched");
    finish_prog();
    wp_pin = 1'b0;
    head(8'haa, 8'h47);
    i_twowire_master.start();
    i_twowire_master.write_byte(8'hab, ack);
    chk_bit(read_dir, 1'b1, "read direction");
    i_twowire_master.read_byte(got, 1'b1);
    chk_byte(got, 8'hc5, "first read byte");
    i_twowire_master.read_byte(got, 1'b0);
    chk_byte(got, 8'hc5, "second read byte");
    i_twowire_master.stop();
    settle();
    chk_byte(rdq_cnt, 8'h02, "read requests");
    chk_bit(standby, 1'b1, "standby after read");
    for (int k = 0; k < 3; k++) begin
      probe(bad_addr[k], 1'b0);
      chk_bit(standby, 1'b1, "standby after nack");
    end
    i_twowire_master.start();
    i_twowire_master.write_byte(8'haa, ack);
    @(negedge clk);
    bor_act = 1'b1;
    settle();
    chk_bit(standby, 1'b1, "brown-out abort");
    chk_bit(sda_oe, 1'b0, "brown-out releases bus");
    probe(8'haa, 1'b0);
    bor_act = 1'b0;
    settle();
    i_twowire_master.recover();
    settle();
    probe(8'haa, 1'b1);
    por_act = 1'b1;
    settle();
    probe(8'haa, 1'b0);
    por_act = 1'b0;
    settle();
    chk_bit(standby, 1'b1, "standby after power-on");
    probe(8'haa, 1'b1);
    conclude();
  end
endmodule

// ===== testbench/twowire_master.sv
/*
  Behavioural two-wire bus master driving SCL and pulling SDA low.
  Assumes the bench resolves the SDA wire with a pull-up and feeds it back.
*/
`timescale 1ns/1ps
module twowire_master (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  localparam real QTR  = 31.25;
  localparam real HALF = 62.5;

  // scl stands high between frames
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic start();
    #(QTR) sda_low = 1'b0;
    #(QTR) scl = 1'b1;
    #(HALF) sda_low = 1'b1;
    #(HALF) scl = 1'b0;
  endtask

  task automatic stop();
    #(QTR) sda_low = 1'b1;
    #(QTR) scl = 1'b1;
    #(HALF) sda_low = 1'b0;
    #(HALF);
  endtask

  // data moves only while scl is low, sampled mid high phase
  task automatic clock_bit(input logic b, output logic r);
    if (scl) begin
      #(QTR) scl = 1'b0;
    end
    #(QTR) sda_low = ~b;
    #(QTR) scl = 1'b1;
    #(QTR) r = sda;
    #(QTR) scl = 1'b0;
  endtask

  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(d[i], r);
    end
    clock_bit(1'b1, r);
    ack = ~r;
  endtask

  task automatic read_byte(output logic [7:0] d, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, r);
      d[i] = r;
    end
    clock_bit(~ack, r);
  endtask

  task automatic recover();
    logic r;
    start();
    for (int i = 0; i < 9; i++) begin
      clock_bit(1'b1, r);
    end
    start();
    stop();
  endtask
endmodule
